// ---- pbtc_pkg.sv ----
/*
 * pbtc_pkg: shared constants for the packet buffer and transmit control
 * block: register offsets, pointer field positions, command encodings,
 * link response codes and buffer layout figures.
 * Assumes: included in compile order before every pbtc design file.
 */
package pbtc_pkg;

   // ----------------------------------------------------------------
   // register offsets on the host bus
   // ----------------------------------------------------------------
   localparam logic [2:0] OFS_PTR_UPPER = 3'h2;
   localparam logic [2:0] OFS_PTR_LOWER = 3'h3;
   localparam logic [2:0] OFS_DATA_PORT = 3'h4;

   // ----------------------------------------------------------------
   // upper pointer fields and reset values
   // ----------------------------------------------------------------
   localparam int         PTR_READ_BIT  = 7;
   localparam int         PTR_STEP_BIT  = 6;
   localparam int         ADDR_W        = 11;
   localparam int         ADDR_HI_W     = ADDR_W - 8;
   localparam logic [7:0] PTR_RESET     = 8'h00;
   localparam logic [7:0] DATA_RESET    = 8'h00;

   // ----------------------------------------------------------------
   // ram organisation and buffer layout
   // ----------------------------------------------------------------
   localparam int          RAM_DEPTH    = 2048;
   localparam int          PAGE_BYTES   = 512;
   localparam int          HALF_BYTES   = 256;
   localparam logic [8:0]  OFS_DEST     = 9'h001;
   localparam logic [8:0]  OFS_COUNT    = 9'h002;
   localparam logic [8:0]  OFS_LCOUNT   = 9'h003;
   localparam logic [8:0]  SHORT_END    = 9'h0FF;
   localparam logic [8:0]  LONG_END     = 9'h1FF;
   localparam logic [7:0]  BROADCAST_ID = 8'h00;

   // ----------------------------------------------------------------
   // command word encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] CMD_TX_ENABLE = 3'h3;
   localparam logic [7:0] CMD_TX_CANCEL = 8'h01;
   localparam int         CMD_HALF_BIT  = 5;
   localparam int         CMD_PAGE_LSB  = 3;

   // ----------------------------------------------------------------
   // link responses and refusal flag threshold
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_ACK      = 2'h0;
   localparam logic [1:0] RESP_NAK      = 2'h1;
   localparam logic [1:0] RESP_NONE     = 2'h2;
   localparam logic [1:0] RESP_NOISE    = 2'h3;
   localparam logic [7:0] NAK_LIMIT     = 8'h80;

endpackage

// ---- pbtc_arb_div.sv ----
/*
 * pbtc_arb_div: ram arbitration rate. gives a one-cycle tick every
 * cycle, or every second cycle when the half-rate setup bit is set.
 * Assumes: slow_in is a register bit on the same clock.
 */
`timescale 1ns/1ps
module pbtc_arb_div (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic slow_in,
   output logic      tick_out
);

   logic phase;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
      end
   end

   // halving relaxes the input clock duty cycle at the cost of speed
   assign tick_out = slow_in ? phase : 1'b1;

endmodule

// ---- pbtc_ram.sv ----
/*
 * pbtc_ram: 2K x 8 packet storage in flip-flops, one write port and
 * one combinational read port, both addressed by an index.
 * Assumes: the caller arbitrates so one access happens per cycle.
 */
`timescale 1ns/1ps
module pbtc_ram (
   input  wire logic                      clk_in,
   input  wire logic                      we_in,
   input  wire logic [pbtc_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [7:0]                wdata_in,
   output logic      [7:0]                rdata_out
);

   logic [7:0] mem [pbtc_pkg::RAM_DEPTH];

   // no reset: buffer contents are undefined until software fills them
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
   end

   assign rdata_out = mem[addr_in];

endmodule

// ---- pbtc_top.sv ----
/*
 * pbtc_top: pointer access port to the packet ram plus the transmit
 * sequencer (enquiry, send, acknowledge, retry, cancel).
 * Assumes: host bus pins are asynchronous and are synchronised here;
 * command, link and setup inputs come from logic on CORE_CLK_IN.
 */
`timescale 1ns/1ps

module pbtc_top (
   input  wire logic       CORE_CLK_IN,
   input  wire logic       RST_B_IN,
   input  wire logic [2:0] HOST_ADDR_IN,
   input  wire logic [7:0] HOST_DATA_IN,
   input  wire logic       HOST_RD_B_IN,
   input  wire logic       HOST_WR_B_IN,
   output logic      [7:0] HOST_DATA_OUT,
   output logic            HOST_DATA_OE_OUT,
   input  wire logic       SETUP_SLOW_ARB_IN,
   input  wire logic       LONG_PKT_EN_IN,
   input  wire logic [7:0] NODE_ID_IN,
   input  wire logic       CMD_STROBE_IN,
   input  wire logic [7:0] CMD_IN,
   input  wire logic       MASK_TX_AVAIL_IN,
   input  wire logic       MASK_EXC_REFUSAL_IN,
   input  wire logic       TOKEN_IN,
   input  wire logic       RESP_VALID_IN,
   input  wire logic [1:0] RESP_CODE_IN,
   input  wire logic       TX_BYTE_READY_IN,
   output logic      [7:0] TX_BYTE_OUT,
   output logic            TX_BYTE_VALID_OUT,
   output logic            TX_LAST_OUT,
   output logic            FBE_REQ_OUT,
   output logic      [7:0] FBE_DEST_OUT,
   output logic            PASS_TOKEN_OUT,
   output logic            TX_AVAILABLE_OUT,
   output logic            TX_ACKED_OUT,
   output logic            EXC_REFUSAL_OUT,
   output logic            IRQ_OUT
);

   localparam int AW = pbtc_pkg::ADDR_W;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_TOKEN = 7'h02,
      ST_HDR   = 7'h04,
      ST_FBE   = 7'h08,
      ST_SEND  = 7'h10,
      ST_OUT   = 7'h20,
      ST_ACK   = 7'h40
   } pbtc_state_t;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [12:0] sync_a;
   logic [12:0] sync_b;
   logic        rd_q;
   logic        wr_q;
   logic [2:0]  bus_addr;
   logic [7:0]  bus_data;
   logic        rd_act;
   logic        wr_act;
   logic        rd_done;
   logic        wr_start;

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         sync_a <= 13'h1800;
         sync_b <= 13'h1800;
         rd_q   <= 1'b0;
         wr_q   <= 1'b0;
      end else begin
         sync_a <= {~HOST_RD_B_IN, ~HOST_WR_B_IN, HOST_ADDR_IN,
                    HOST_DATA_IN} ^ 13'h1800;
         sync_b <= sync_a;
         rd_q   <= rd_act;
         wr_q   <= wr_act;
      end
   end

   // stored inverted so reset leaves both strobes idle
   assign rd_act   = ~sync_b[12];
   assign wr_act   = ~sync_b[11];
   assign bus_addr = sync_b[10:8];
   assign bus_data = sync_b[7:0];
   assign rd_done  = rd_q & ~rd_act;
   assign wr_start = wr_act & ~wr_q;

   // ----------------------------------------------------------------
   // ram arbitration
   // ----------------------------------------------------------------
   logic          arb_tick;
   logic          host_fetch;
   logic          host_commit;
   logic          tx_req;
   logic [AW-1:0] host_addr;
   logic [AW-1:0] commit_addr;
   logic [AW-1:0] tx_addr;
   logic [7:0]    hold_data;
   logic [7:0]    ram_rdata;
   logic          grant_host;
   logic          grant_tx;
   logic          ram_we;
   logic [AW-1:0] ram_addr;

   pbtc_arb_div u_div (
      .clk_in   (CORE_CLK_IN),
      .rst_b_in (RST_B_IN),
      .slow_in  (SETUP_SLOW_ARB_IN),
      .tick_out (arb_tick)
   );

   // host first: a stalled host data register is what software sees
   assign grant_host = arb_tick & (host_fetch | host_commit);
   assign grant_tx   = arb_tick & ~(host_fetch | host_commit) & tx_req;
   assign ram_we     = grant_host & host_commit;
   assign ram_addr   = ~grant_host ? tx_addr :
                       host_commit ? commit_addr : host_addr;

   pbtc_ram u_ram (
      .clk_in    (CORE_CLK_IN),
      .we_in     (ram_we),
      .addr_in   (ram_addr),
      .wdata_in  (hold_data),
      .rdata_out (ram_rdata)
   );

   // ----------------------------------------------------------------
   // host pointer and data port
   // ----------------------------------------------------------------
   logic [7:0] ptr_upper;
   logic [7:0] ptr_lower;
   logic       step_en;

   assign step_en   = ptr_upper[pbtc_pkg::PTR_STEP_BIT];
   assign host_addr = {ptr_upper[pbtc_pkg::ADDR_HI_W-1:0], ptr_lower};

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         ptr_upper <= pbtc_pkg::PTR_RESET;
         ptr_lower <= pbtc_pkg::PTR_RESET;
      end else if (wr_start && bus_addr == pbtc_pkg::OFS_PTR_UPPER) begin
         ptr_upper <= bus_data;
      end else if (wr_start && bus_addr == pbtc_pkg::OFS_PTR_LOWER) begin
         ptr_lower <= bus_data;
      end else if (step_en && ((wr_start &&
                   bus_addr == pbtc_pkg::OFS_DATA_PORT) ||
                   (rd_done && bus_addr == pbtc_pkg::OFS_DATA_PORT))) begin
         // advanced address stays readable in both pointers
         {ptr_upper[pbtc_pkg::ADDR_HI_W-1:0], ptr_lower} <=
            host_addr + AW'(1);
      end
   end

   // read fetch pending: after a load in read mode or after a stepped read
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         host_fetch <= 1'b0;
      end else if (wr_start && bus_addr == pbtc_pkg::OFS_PTR_LOWER) begin
         host_fetch <= ptr_upper[pbtc_pkg::PTR_READ_BIT];
      end else if (rd_done && step_en &&
                   bus_addr == pbtc_pkg::OFS_DATA_PORT) begin
         host_fetch <= 1'b1;
      end else if (grant_host && !host_commit) begin
         host_fetch <= 1'b0;
      end
   end

   // write-back holding register: host cycle never waits on the ram
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         hold_data   <= pbtc_pkg::DATA_RESET;
         host_commit <= 1'b0;
         commit_addr <= '0;
      end else if (wr_start && bus_addr == pbtc_pkg::OFS_DATA_PORT) begin
         hold_data   <= bus_data;
         host_commit <= 1'b1;
         commit_addr <= host_addr;
      end else if (grant_host && host_fetch && !host_commit) begin
         hold_data <= ram_rdata;
      end else if (grant_host && host_commit) begin
         host_commit <= 1'b0;
      end
   end

   // read mux into a flop; bus driven only while the read strobe is seen
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         HOST_DATA_OUT    <= 8'h00;
         HOST_DATA_OE_OUT <= 1'b0;
      end else begin
         HOST_DATA_OE_OUT <= rd_act;
         unique case (bus_addr)
            pbtc_pkg::OFS_PTR_UPPER: HOST_DATA_OUT <= ptr_upper;
            pbtc_pkg::OFS_PTR_LOWER: HOST_DATA_OUT <= ptr_lower;
            pbtc_pkg::OFS_DATA_PORT: HOST_DATA_OUT <= hold_data;
            default:                 HOST_DATA_OUT <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // transmit command and flags
   // ----------------------------------------------------------------
   pbtc_state_t   state;
   logic [AW-1:0] page_base;
   logic [8:0]    idx;
   logic [8:0]    end_idx;
   logic [8:0]    hdr_last;
   logic [7:0]    dest;
   logic [7:0]    cnt_short;
   logic          is_long;
   logic          cancel_pend;
   logic [7:0]    nak_count;
   logic          tx_avail;
   logic          tx_acked;
   logic          exc_refusal;
   logic          cmd_enable;
   logic          cmd_cancel;
   logic          resp_ack;

   assign cmd_enable = CMD_STROBE_IN &&
                       CMD_IN[2:0] == pbtc_pkg::CMD_TX_ENABLE && tx_avail;
   assign cmd_cancel = CMD_STROBE_IN && CMD_IN == pbtc_pkg::CMD_TX_CANCEL;
   assign resp_ack   = RESP_VALID_IN && RESP_CODE_IN == pbtc_pkg::RESP_ACK;

   // page times 512 plus half bit times 256
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         page_base <= '0;
      end else if (cmd_enable) begin
         page_base <= {CMD_IN[pbtc_pkg::CMD_PAGE_LSB+1:pbtc_pkg::CMD_PAGE_LSB],
                       CMD_IN[pbtc_pkg::CMD_HALF_BIT], 8'h00};
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         cancel_pend <= 1'b0;
      end else if (cmd_cancel && state != ST_IDLE) begin
         cancel_pend <= 1'b1;
      end else if (state == ST_IDLE) begin
         cancel_pend <= 1'b0;
      end
   end

   // enable clears both; completion paths set tx_avail, only an acknowledge in ST_ACK sets tx_acked
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         tx_avail <= 1'b1;
         tx_acked <= 1'b0;
      end else if (cmd_enable) begin
         tx_avail <= 1'b0;
         tx_acked <= 1'b0;
      end else if (state == ST_ACK && RESP_VALID_IN) begin
         tx_avail <= 1'b1;
         tx_acked <= resp_ack;
      end else if (state == ST_FBE && RESP_VALID_IN &&
                   RESP_CODE_IN == pbtc_pkg::RESP_NONE) begin
         tx_avail <= 1'b1;
      end else if (state == ST_TOKEN && TOKEN_IN && cancel_pend) begin
         tx_avail <= 1'b1;
      end
   end

   // refusal counter and sticky diagnostic flag
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         nak_count   <= 8'h00;
         exc_refusal <= 1'b0;
      end else if (state == ST_FBE && RESP_VALID_IN &&
                   RESP_CODE_IN == pbtc_pkg::RESP_NAK) begin
         nak_count <= nak_count + 8'h01;
         if (nak_count + 8'h01 >= pbtc_pkg::NAK_LIMIT) begin
            exc_refusal <= 1'b1;
         end
      end else if (cmd_enable) begin
         nak_count   <= 8'h00;
         exc_refusal <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // transmit sequencer
   // ----------------------------------------------------------------
   assign tx_req  = state == ST_HDR ||
                    (state == ST_SEND &&
                     (!TX_BYTE_VALID_OUT || TX_BYTE_READY_IN));
   assign tx_addr = page_base + AW'(idx);
   // no boundary check: the page size alone bounds a buffer
   assign end_idx = is_long ? pbtc_pkg::LONG_END : pbtc_pkg::SHORT_END;
   assign hdr_last = is_long ? pbtc_pkg::OFS_LCOUNT : pbtc_pkg::OFS_COUNT;

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         state          <= ST_IDLE;
         idx            <= 9'h000;
         dest           <= 8'h00;
         cnt_short      <= 8'h00;
         is_long        <= 1'b0;
         FBE_REQ_OUT    <= 1'b0;
         PASS_TOKEN_OUT <= 1'b0;
      end else begin
         FBE_REQ_OUT    <= 1'b0;
         PASS_TOKEN_OUT <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (cmd_enable) begin
                  state <= ST_TOKEN;
               end
            end
            ST_TOKEN: begin
               if (TOKEN_IN && cancel_pend) begin
                  PASS_TOKEN_OUT <= 1'b1;
                  state          <= ST_IDLE;
               end else if (TOKEN_IN) begin
                  idx     <= pbtc_pkg::OFS_DEST;
                  is_long <= 1'b0;
                  state   <= ST_HDR;
               end
            end
            ST_HDR: begin
               if (grant_tx) begin
                  if (idx == pbtc_pkg::OFS_DEST) begin
                     dest <= ram_rdata;
                     idx  <= pbtc_pkg::OFS_COUNT;
                  end else begin
                     cnt_short <= ram_rdata;
                     is_long   <= LONG_PKT_EN_IN &&
                                  ram_rdata == 8'h00;
                     if (dest == pbtc_pkg::BROADCAST_ID) begin
                        state <= ST_OUT;
                     end else begin
                        FBE_REQ_OUT <= 1'b1;
                        state       <= ST_FBE;
                     end
                  end
               end
            end
            ST_FBE: begin
               if (RESP_VALID_IN) begin
                  unique case (RESP_CODE_IN)
                     pbtc_pkg::RESP_ACK: state <= ST_OUT;
                     pbtc_pkg::RESP_NAK: begin
                        PASS_TOKEN_OUT <= 1'b1;
                        state          <= ST_TOKEN;
                     end
                     pbtc_pkg::RESP_NONE: begin
                        PASS_TOKEN_OUT <= 1'b1;
                        state          <= ST_IDLE;
                     end
                     pbtc_pkg::RESP_NOISE: state <= ST_TOKEN;
                  endcase
               end
            end
            ST_OUT: begin
               // byte 0 comes from the node id, not the buffer
               if (!TX_BYTE_VALID_OUT || TX_BYTE_READY_IN) begin
                  idx   <= pbtc_pkg::OFS_DEST;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (grant_tx) begin
                  if (idx == end_idx) begin
                     state <= ST_ACK;
                  end else if (idx == hdr_last) begin
                     // skip unused gap to the first information byte
                     // data ends at end_idx (0xFF short, 0x1FF long), so it starts at the count
                     idx <= {1'b0, is_long ? ram_rdata : cnt_short};
                  end else begin
                     idx <= idx + 9'h001;
                  end
               end
            end
            ST_ACK: begin
               if (RESP_VALID_IN) begin
                  PASS_TOKEN_OUT <= 1'b1;
                  state          <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outgoing byte stream
   // ----------------------------------------------------------------
   logic send_go;

   // the fetch waits while the previous byte is still unaccepted
   assign send_go = state == ST_SEND && grant_tx;

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         TX_BYTE_OUT       <= 8'h00;
         TX_BYTE_VALID_OUT <= 1'b0;
         TX_LAST_OUT       <= 1'b0;
      end else if (state == ST_OUT &&
                   (!TX_BYTE_VALID_OUT || TX_BYTE_READY_IN)) begin
         TX_BYTE_OUT       <= NODE_ID_IN;
         TX_BYTE_VALID_OUT <= 1'b1;
         TX_LAST_OUT       <= 1'b0;
      end else if (send_go) begin
         TX_BYTE_OUT       <= ram_rdata;
         TX_BYTE_VALID_OUT <= 1'b1;
         TX_LAST_OUT       <= idx == end_idx;
      end else if (TX_BYTE_READY_IN) begin
         TX_BYTE_VALID_OUT <= 1'b0;
         TX_LAST_OUT       <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------
   assign FBE_DEST_OUT     = dest;
   assign TX_AVAILABLE_OUT = tx_avail;
   assign TX_ACKED_OUT     = tx_acked;
   assign EXC_REFUSAL_OUT  = exc_refusal;
   assign IRQ_OUT = (tx_avail & MASK_TX_AVAIL_IN) |
                    (exc_refusal & MASK_EXC_REFUSAL_IN);

endmodule

// ---- pbtc_chk_asserts.sv ----
/* pbtc_chk: assertions on the transmit ports and host data enable of pbtc_top.
   Assumes: bound to pbtc_top; one clock, sync active-low reset. */
`timescale 1ns/1ps
module pbtc_chk (
   input wire logic       CORE_CLK_IN,
   input wire logic       RST_B_IN,
   input wire logic       HOST_RD_B_IN,
   input wire logic       HOST_DATA_OE_OUT,
   input wire logic       CMD_STROBE_IN,
   input wire logic [7:0] CMD_IN,
   input wire logic       TX_BYTE_READY_IN,
   input wire logic [7:0] TX_BYTE_OUT,
   input wire logic       TX_BYTE_VALID_OUT,
   input wire logic       FBE_REQ_OUT,
   input wire logic [7:0] FBE_DEST_OUT,
   input wire logic       PASS_TOKEN_OUT,
   input wire logic       TX_AVAILABLE_OUT,
   input wire logic       TX_ACKED_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   a_enable_clears: assert property (
      CMD_STROBE_IN && CMD_IN[2:0] == pbtc_pkg::CMD_TX_ENABLE
      && TX_AVAILABLE_OUT |=> !TX_AVAILABLE_OUT && !TX_ACKED_OUT)
      else $error("flags kept");
   a_fbe_pulse: assert property (
      FBE_REQ_OUT |=> !FBE_REQ_OUT) else $error("enquiry too long");
   a_fbe_dest: assert property (
      FBE_REQ_OUT |-> FBE_DEST_OUT != pbtc_pkg::BROADCAST_ID)
      else $error("dest");
   a_fbe_busy: assert property (
      FBE_REQ_OUT |-> !TX_AVAILABLE_OUT) else $error("enquiry while idle");
   a_pass_pulse: assert property (
      PASS_TOKEN_OUT |=> !PASS_TOKEN_OUT) else $error("pass too long");
   a_acked_avail: assert property (
      TX_ACKED_OUT |-> TX_AVAILABLE_OUT) else $error("acked not available");
   a_stream_busy: assert property (
      TX_BYTE_VALID_OUT |-> !TX_AVAILABLE_OUT)
      else $error("stream while idle");
   a_byte_hold: assert property (
      TX_BYTE_VALID_OUT && !TX_BYTE_READY_IN |=> TX_BYTE_VALID_OUT
      && $stable(TX_BYTE_OUT)) else $error("byte dropped");
   a_oe_read_on: assert property (
      !HOST_RD_B_IN ##3 !HOST_RD_B_IN |-> HOST_DATA_OE_OUT)
      else $error("read data not driven");
   a_oe_read_off: assert property (
      HOST_RD_B_IN ##3 HOST_RD_B_IN |-> !HOST_DATA_OE_OUT)
      else $error("bus driven while idle");
endmodule
bind pbtc_top pbtc_chk u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
   .HOST_RD_B_IN(HOST_RD_B_IN), .HOST_DATA_OE_OUT(HOST_DATA_OE_OUT),
   .CMD_STROBE_IN(CMD_STROBE_IN), .CMD_IN(CMD_IN),
   .TX_BYTE_READY_IN(TX_BYTE_READY_IN), .TX_BYTE_OUT(TX_BYTE_OUT),
   .TX_BYTE_VALID_OUT(TX_BYTE_VALID_OUT), .FBE_REQ_OUT(FBE_REQ_OUT),
   .FBE_DEST_OUT(FBE_DEST_OUT), .PASS_TOKEN_OUT(PASS_TOKEN_OUT),
   .TX_AVAILABLE_OUT(TX_AVAILABLE_OUT), .TX_ACKED_OUT(TX_ACKED_OUT));

// ---- pbtc_host.sv ----
/* pbtc_host: host model on the pointer register bus.
   Assumes: strobes are synced in the device, 4 cycles each way suffice. */
`timescale 1ns/1ps
module pbtc_host (
   input  wire logic       clk_in,
   input  wire logic [7:0] data_in,
   output logic      [2:0] addr_out,
   output logic      [7:0] data_out,
   output logic            rd_b_out,
   output logic            wr_b_out
);
   initial {addr_out, data_out, rd_b_out, wr_b_out} = 13'h3;
   task automatic cyc(input logic [2:0] a, input logic [7:0] d,
                      input logic rd, output logic [7:0] q);
      @(posedge clk_in) {addr_out, data_out} <= {a, d};
      {rd_b_out, wr_b_out} <= {!rd, rd};
      repeat (3) @(posedge clk_in);
      @(negedge clk_in) q = data_in;
      // released bus flips so stale data never matches
      @(posedge clk_in) {data_out, rd_b_out, wr_b_out} <= {~d, 2'h3};
      repeat (4) @(posedge clk_in);
   endtask
   // upper then lower, 8 spare cycles before data
   task automatic ptr(input logic [10:0] a, input logic rd);
      logic [7:0] q;
      cyc(3'h2, {rd, 1'h1, 3'h5, a[10:8]}, 1'h0, q); // junk bits
      cyc(3'h3, a[7:0], 1'h0, q);
      repeat (8) @(posedge clk_in);
   endtask
endmodule

// ---- pbtc_bench.sv ----
/* pbtc_bench: directed bench for pbtc_top with a host model.
   Assumes: package, design, host and checker compiled first. */
`timescale 1ns/1ps
module pbtc_bench;
   logic       clk = 1'h0, rst_b = 1'h0, slow = 1'h0, ready = 1'h0;
   logic       strobe = 1'h0, token = 1'h0, rvalid = 1'h0;
   logic       long_en = 1'h0;
   logic [7:0] lhdr [4] = '{8'h5A, 8'h07, 8'h00, 8'hFF};
   logic [7:0] cmd = 8'h0, hdin, hdout, tx_byte, dest, d;
   logic [7:0] pkt [5] = '{8'h5A, 8'h07, 8'hFE, 8'hA1, 8'hA2};
   logic [2:0] haddr;
   logic [1:0] rcode = 2'h0;
   logic       rd_b, wr_b, valid, fbe, pass, avail, acked, exc, irq, last;
   int         miscompares = 0, cmp_count = 0;
   pbtc_host host (.clk_in(clk), .data_in(hdout), .addr_out(haddr),
      .data_out(hdin), .rd_b_out(rd_b), .wr_b_out(wr_b));
   pbtc_top uut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .HOST_ADDR_IN(haddr),
      .HOST_DATA_IN(hdin), .HOST_RD_B_IN(rd_b), .HOST_WR_B_IN(wr_b),
      .HOST_DATA_OUT(hdout), .HOST_DATA_OE_OUT(), .SETUP_SLOW_ARB_IN(slow),
      .LONG_PKT_EN_IN(long_en), .NODE_ID_IN(8'h5A), .CMD_STROBE_IN(strobe),
      .CMD_IN(cmd), .MASK_TX_AVAIL_IN(1'h1), .MASK_EXC_REFUSAL_IN(1'h1),
      .TOKEN_IN(token), .RESP_VALID_IN(rvalid), .RESP_CODE_IN(rcode),
      .TX_BYTE_READY_IN(ready), .TX_BYTE_OUT(tx_byte), .FBE_REQ_OUT(fbe),
      .TX_BYTE_VALID_OUT(valid), .TX_LAST_OUT(last), .FBE_DEST_OUT(dest),
      .PASS_TOKEN_OUT(pass), .TX_AVAILABLE_OUT(avail), .TX_ACKED_OUT(acked),
      .EXC_REFUSAL_OUT(exc), .IRQ_OUT(irq));
   task automatic check(input logic [8:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d bad %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_hi(ref logic s);
      int n;
      for (n = 0; n < 300 && s !== 1'h1; n++) @(negedge clk);
      if (s !== 1'h1) begin
         miscompares++;
         complete_run;
      end
   endtask
   task automatic stim(input int k, input logic [7:0] v);
      @(posedge clk) {cmd, rcode} <= {v, v[1:0]};
      {strobe, token, rvalid} <= {k == 0, k == 1, k == 2};
      @(posedge clk) {strobe, token, rvalid} <= 3'h0;
      @(negedge clk);
   endtask
   task automatic enq(input logic [1:0] r);
      stim(1, 8'h0);
      wait_hi(fbe);
      check(dest, 9'h07);
      stim(2, {6'h0, r});
   endtask
   task automatic t_ptr;
      host.ptr(11'h300, 1'h0);
      for (int i = 0; i < 3; i++) host.cyc(3'h4, i ? pkt[i] : 8'hEE, 1'h0, d);
      host.cyc(3'h3, 8'h0, 1'h1, d);
      check(d, 9'h03);
      host.ptr(11'h3FE, 1'h0); // two info bytes
      for (int i = 3; i < 5; i++) host.cyc(3'h4, pkt[i], 1'h0, d);
      @(posedge clk) slow <= 1'h1;
      host.ptr(11'h301, 1'h1);
      for (int i = 1; i < 3; i++) begin
         host.cyc(3'h4, 8'h0, 1'h1, d);
         check(d, pkt[i]);
      end
   endtask
   task automatic t_tx;
      stim(0, 8'h2B); // page 1 plus half page
      check({avail, acked}, 9'h0);
      enq(pbtc_pkg::RESP_NAK);
      wait_hi(pass);
      enq(pbtc_pkg::RESP_ACK);
      wait_hi(valid);
      // node id must stand while the sink stalls
      @(posedge clk) ready <= 1'h1;
      @(negedge clk);
      for (int i = 0; i < 5; i++) begin
         wait_hi(valid);
         check({last, tx_byte}, {i == 4, pkt[i]});
         @(posedge clk);
         @(negedge clk);
      end
      stim(2, pbtc_pkg::RESP_ACK);
      wait_hi(avail);
      check({acked, irq}, 9'h3);
      stim(0, 8'h2B);
      enq(pbtc_pkg::RESP_NONE);
      wait_hi(avail);
      check(acked, 9'h0);
   endtask
   task automatic t_long;
      @(posedge clk) long_en <= 1'h1;
      host.ptr(11'h001, 1'h0);
      for (int i = 1; i < 4; i++) host.cyc(3'h4, lhdr[i], 1'h0, d);
      host.ptr(11'h0FF, 1'h0); // 257 info bytes
      for (int i = 0; i < 257; i++) host.cyc(3'h4, 8'(i), 1'h0, d);
      stim(0, 8'h03); // page 0, no half page
      enq(pbtc_pkg::RESP_ACK);
      for (int i = 0; i < 261; i++) begin
         wait_hi(valid);
         check({last, tx_byte},
               {i == 260, i < 4 ? lhdr[i] : 8'(i - 4)});
         @(posedge clk);
         @(negedge clk);
      end
      stim(2, pbtc_pkg::RESP_ACK);
      wait_hi(avail);
      check(acked, 9'h1);
   endtask
   task automatic t_nak;
      int n;
      stim(0, 8'h2B);
      repeat (128) begin
         enq(pbtc_pkg::RESP_NAK);
         wait_hi(pass);
      end
      check({exc, irq}, 9'h3);
      enq(pbtc_pkg::RESP_NOISE);
      n = 0;
      repeat (40) @(negedge clk) n += pass;
      check(n[8:0], 9'h0);
      stim(0, pbtc_pkg::CMD_TX_CANCEL);
      stim(1, 8'h0);
      wait_hi(avail);
      check(acked, 9'h0);
   endtask
   initial forever #4 clk = ~clk;
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      t_ptr;
      t_tx;
      t_long;
      t_nak;
      complete_run;
   end
endmodule
